//--- src/cts_built_in_self_check.v
`timescale 1ns/10ps
`default_nettype none
`include "cts_defs.vh"
module cts_selfchk #(
   parameter CHECK_CLKS = `CTS_CHECK_CLKS
) (
   input  wire        clock,
   input  wire        reset_n,
   input  wire        start,
   output reg         op_valid,
   output reg         op_wr,
   output reg  [2:0]  op_num,
   output reg  [31:0] op_wdata,
   input  wire [31:0] rd_data,
   output reg         done,
   output reg  [31:0] errors
);
   reg        run_reg;
   reg [4:0]  step_reg;
   reg [8:0]  idx_reg;
   reg        pass_reg;
   reg        swept_reg;
   reg [19:0] cyc_reg;
   reg        chk_reg;
   reg [31:0] exp_reg;
   reg [31:0] mask_reg;

   wire [31:0] pat   = pass_reg ? `CTS_PAT1 : `CTS_PAT0;
   wire [20:0] tag   = pat[20:0] ^ {12'h000, idx_reg};
   wire [4:0]  rstep = step_reg - `CTS_STEP_RBUF;
   wire [1:0]  word  = (step_reg < `CTS_STEP_BUF_END) ? step_reg[2:1]
                                                      : rstep[2:1];

   function [31:0] word_pat;
      input [31:0] p;
      input [8:0]  i;
      input [1:0]  k;
      word_pat = p ^ {21'h000000, i, k};
   endfunction

   function [31:0] ctl_word;
      input [6:0] s;
      input [1:0] e;
      input [1:0] c;
      ctl_word = {21'h000000, s, e, c};
   endfunction

   // Walks the same test register operations software would use [R06]
   always @* begin
      op_valid = run_reg && !swept_reg;
      op_wr    = 1'b1;
      op_num   = `CTS_OPND_CONTROL;
      op_wdata = 32'h0000_0000;
      if (step_reg < `CTS_STEP_BUF_END || (step_reg >= `CTS_STEP_RBUF &&
          step_reg <= `CTS_STEP_LAST)) begin
         if (step_reg[0] == 1'b0) begin
            op_wdata = ctl_word(7'h00, word, `CTS_CODE_BUF);
         end else begin
            op_num   = `CTS_OPND_DATA;
            op_wr    = (step_reg < `CTS_STEP_BUF_END);
            op_wdata = word_pat(pat, idx_reg, word);
         end
      end else if (step_reg == `CTS_STEP_STAT_WR) begin
         op_num   = `CTS_OPND_STATUS;
         op_wdata = {tag, 1'b1, 10'h000};
      end else if (step_reg == `CTS_STEP_WRITE) begin
         op_wdata = ctl_word(idx_reg[8:2], idx_reg[1:0], `CTS_CODE_WRITE);
      end else if (step_reg == `CTS_STEP_READ) begin
         op_wdata = ctl_word(idx_reg[8:2], idx_reg[1:0], `CTS_CODE_READ);
      end else if (step_reg == `CTS_STEP_STAT_RD) begin
         op_num = `CTS_OPND_STATUS;
         op_wr  = 1'b0;
      end else begin
         op_wdata = ctl_word(7'h00, 2'h0, `CTS_CODE_FLUSH);
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         run_reg   <= 1'b0;
         step_reg  <= 5'd0;
         idx_reg   <= 9'd0;
         pass_reg  <= 1'b0;
         swept_reg <= 1'b0;
         cyc_reg   <= 20'd0;
         chk_reg   <= 1'b0;
         exp_reg   <= 32'h0000_0000;
         mask_reg  <= 32'h0000_0000;
         errors    <= 32'h0000_0000;
         done      <= 1'b0;
      end else begin
         done    <= 1'b0;
         chk_reg <= 1'b0;
         if (start && !run_reg) begin
            run_reg   <= 1'b1;
            step_reg  <= 5'd0;
            idx_reg   <= 9'd0;
            pass_reg  <= 1'b0;
            swept_reg <= 1'b0;
            cyc_reg   <= 20'd0;
            errors    <= 32'h0000_0000;
         end else if (run_reg) begin
            cyc_reg <= cyc_reg + 20'd1;
            // Compare one clock after the read; read data is registered [R07]
            if (chk_reg && ((rd_data ^ exp_reg) & mask_reg) != 32'h0)
               errors <= errors + 32'h0000_0001;
            if (!swept_reg) begin
               if (step_reg == `CTS_STEP_STAT_RD) begin
                  chk_reg  <= 1'b1;
                  exp_reg  <= {tag, 1'b1, 10'h000};
                  mask_reg <= `CTS_STAT_TAGMASK;
               end else if (step_reg[0] && step_reg > `CTS_STEP_RBUF &&
                            step_reg <= `CTS_STEP_LAST) begin
                  chk_reg  <= 1'b1;
                  exp_reg  <= word_pat(pat, idx_reg, word);
                  mask_reg <= 32'hffff_ffff;
               end
               if (step_reg == `CTS_STEP_FLUSH) begin
                  swept_reg <= 1'b1;
               end else if (step_reg == `CTS_STEP_LAST) begin
                  idx_reg <= idx_reg + 9'd1;
                  if (idx_reg == `CTS_ENTRIES - 1) begin
                     pass_reg <= 1'b1;
                     step_reg <= pass_reg ? `CTS_STEP_FLUSH : 5'd0;
                  end else begin
                     step_reg <= 5'd0;
                  end
               end else begin
                  step_reg <= step_reg + 5'd1;
               end
            end else if (cyc_reg >= CHECK_CLKS[19:0] - 20'd1) begin
               run_reg <= 1'b0;
               done    <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- src/cts_defs.vh
// Contract
// [R01] Self check starts only if address hold is high 2 clocks around reset release; the code needs 4 synced samples high, all taken before release.
// [R02] No bus cycles while the self check runs; it lasts about 600000 clocks.
// [R03] System holds reset active at least 15 clocks for a warm reset.
// [R04] Self check result goes to the accumulator: zero passes, nonzero flags a flaw.
// [R05] After the self check, run the reset sequence and start normal operation.
// [R06] Self check drives the cache through the data, status and control test registers.
// [R07] Self check writes, reads back and compares every one of 512 cache entries.
// [R08] Separate 128-bit fill buffer and 128-bit read buffer.
// [R09] Software loads the fill buffer before writes, reads into read buffer first.
// [R10] Only the 32-bit data window reaches either buffer, four words each.
// [R11] Entry select picks a buffer word, or one of four entries in a set.
// [R12] Seven-bit set select picks one of 128 sets for write or read.
// [R13] Software loads tag and valid into the status register before a cache write.
// [R14] After a read the status holds tag, valid, set replacement bits, set valids.
// [R15] Two control bits choose buffer access, cache write, cache read or flush.
// [R16] Software sets cache disable and not-write-through before any test operation.
// [R17] Test registers are reached only through move to/from test register operations.
// [R18] Code 01 copies the fill buffer to the entry and updates replacement bits.
// [R19] Code 10 loads read buffer and status with entry tag, valid, set bits.
// [R20] Code 00: data writes fill the selected word, reads return the read word.
// [R21] Code 11 clears replacement and valid bits only, other fields ignored.
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH

// Test register numbers on the operand select
`define CTS_OPND_DATA     3'h3
`define CTS_OPND_STATUS   3'h4
`define CTS_OPND_CONTROL  3'h5

// Control register fields
`define CTS_CODE_LSB      0
`define CTS_ENTRY_LSB     2
`define CTS_SET_LSB       4
`define CTS_CTRL_MASK     32'h000007ff
`define CTS_CODE_BUF      2'h0
`define CTS_CODE_WRITE    2'h1
`define CTS_CODE_READ     2'h2
`define CTS_CODE_FLUSH    2'h3

// Status register fields
`define CTS_TAG_LSB       11
`define CTS_VALID_BIT     10
`define CTS_LRU_LSB       7
`define CTS_SETV_LSB      3
`define CTS_STAT_TAGMASK  32'hfffffc00

// Geometry
`define CTS_SETS          128
`define CTS_ENTRIES       512

// Strap and reset timing, in clocks
`define CTS_HOLD_CLKS     2
`define CTS_RSTSEQ_CLKS   8'd15
`define CTS_CHECK_CLKS    600000

// Self check sequence
`define CTS_PAT0          32'h5a5a_a5a5
`define CTS_PAT1          32'hc33c_0ff0
`define CTS_STEP_BUF_END  5'd8
`define CTS_STEP_STAT_WR  5'd8
`define CTS_STEP_WRITE    5'd9
`define CTS_STEP_READ     5'd10
`define CTS_STEP_STAT_RD  5'd11
`define CTS_STEP_RBUF     5'd12
`define CTS_STEP_LAST     5'd19
`define CTS_STEP_FLUSH    5'd20

`endif

//--- src/cts_sync.v
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser; left without reset so it keeps sampling
// the strap pin while the device reset is still asserted.
module cts_sync (
   input  wire clock,
   input  wire din,
   output wire dout
);
   reg meta_reg;
   reg sync_reg;

   always @(posedge clock) begin
      meta_reg <= din;
      sync_reg <= meta_reg;
   end

   assign dout = sync_reg;
endmodule
`default_nettype wire

//--- src/cts_top.v
`timescale 1ns/10ps
`default_nettype none
`include "cts_defs.vh"
module cts_top #(
   parameter CHECK_CLKS = `CTS_CHECK_CLKS
) (
   input  wire        clock,
   input  wire        reset_n,
   input  wire        address_hold_input,
   input  wire        test_wr,
   input  wire        test_rd,
   input  wire [2:0]  test_register_operand,
   input  wire [31:0] test_wdata,
   output reg  [31:0] test_rdata,
   output reg         test_rd_done,
   output reg         bus_cycle_hold,
   output reg         core_reset,
   output reg         built_in_self_check_busy,
   output reg  [31:0] accumulator
);
   localparam ST_STRAP = 2'd0;
   localparam ST_CHECK = 2'd1;
   localparam ST_RSEQ  = 2'd2;
   localparam ST_RUN   = 2'd3;

   reg [1:0]   state_reg;
   reg [1:0]   post_reg;
   reg [3:0]   hist_reg;
   reg [7:0]   rseq_reg;
   reg         built_in_self_check_go_reg;

   reg [31:0]  data_win_reg;
   reg [31:0]  status_reg;
   reg [31:0]  control_reg;
   reg [127:0] fill_buf_reg;
   reg [127:0] read_buf_reg;

   reg [127:0] data_mem [0:`CTS_ENTRIES-1];
   reg [20:0]  tag_mem  [0:`CTS_ENTRIES-1];
   reg [3:0]   valid_mem[0:`CTS_SETS-1];
   reg [2:0]   lru_mem  [0:`CTS_SETS-1];

   wire        hold_sync;
   wire        b_valid;
   wire        b_wr;
   wire [2:0]  b_num;
   wire [31:0] b_wdata;
   wire        b_done;
   wire [31:0] b_errors;

   cts_sync u_sync (
      .clock (clock),
      .din   (address_hold_input),
      .dout  (hold_sync)
   );

   cts_selfchk #(
      .CHECK_CLKS (CHECK_CLKS)
   ) u_check (
      .clock    (clock),
      .reset_n  (reset_n),
      .start    (built_in_self_check_go_reg),
      .op_valid (b_valid),
      .op_wr    (b_wr),
      .op_num   (b_num),
      .op_wdata (b_wdata),
      .rd_data  (test_rdata),
      .done     (b_done),
      .errors   (b_errors)
   );

   // Pseudo-LRU: root points away from the touched half
   function [2:0] lru_touch;
      input [2:0] l;
      input [1:0] e;
      begin
         case (e)
            2'h0: lru_touch = {l[2], 2'h3};
            2'h1: lru_touch = {l[2], 2'h1};
            2'h2: lru_touch = {1'b1, l[1], 1'b0};
            default: lru_touch = {1'b0, l[1], 1'b0};
         endcase
      end
   endfunction

   // Owner of the test register port: engine in self check, software only in normal run
   wire        in_check = (state_reg == ST_CHECK);
   wire        sw_ok    = (state_reg == ST_RUN);
   wire        op_wr    = in_check ? (b_valid && b_wr) : (sw_ok && test_wr);
   wire        op_rd    = in_check ? (b_valid && !b_wr) : (sw_ok && test_rd);
   wire [2:0]  op_num   = in_check ? b_num : test_register_operand;
   wire [31:0] op_data  = in_check ? b_wdata : test_wdata;

   wire        data_wr  = op_wr && op_num == `CTS_OPND_DATA;
   wire        stat_wr  = op_wr && op_num == `CTS_OPND_STATUS;
   wire        ctl_wr   = op_wr && op_num == `CTS_OPND_CONTROL;
   wire [1:0]  new_code = op_data[`CTS_CODE_LSB +: 2];
   wire [1:0]  new_en   = op_data[`CTS_ENTRY_LSB +: 2];
   wire [6:0]  new_set  = op_data[`CTS_SET_LSB +: 7];
   wire [8:0]  new_idx  = {new_set, new_en};
   wire [1:0]  cur_code = control_reg[`CTS_CODE_LSB +: 2];
   wire [1:0]  cur_en   = control_reg[`CTS_ENTRY_LSB +: 2];
   wire        do_write = ctl_wr && new_code == `CTS_CODE_WRITE;
   wire        do_read  = ctl_wr && new_code == `CTS_CODE_READ;
   wire        do_flush = ctl_wr && new_code == `CTS_CODE_FLUSH;

   // Strap history; the pin is sampled through the synchroniser only
   always @(posedge clock) begin
      hist_reg <= {hist_reg[2:0], hold_sync};
   end

   // Strap read as four synced samples, all high
   wire        strap_ok = &hist_reg;

   // Counts edges since release, frozen once the strap is read
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         post_reg <= 2'd0;
      end else if (state_reg == ST_STRAP) begin
         post_reg <= post_reg + 2'd1;
      end
   end

   // Result held through normal run; zero when no self check ran [R04]
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         accumulator <= 32'h0000_0000;
      end else if (in_check && b_done) begin
         accumulator <= b_errors;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg                <= ST_STRAP;
         rseq_reg                 <= 8'd0;
         built_in_self_check_go_reg              <= 1'b0;
         bus_cycle_hold           <= 1'b1;
         core_reset               <= 1'b1;
         built_in_self_check_busy <= 1'b0;
      end else begin
         built_in_self_check_go_reg <= 1'b0;
         case (state_reg)
            ST_STRAP: begin
               // High at the last 4 clock edges before release, none after [R01]
               if (post_reg == `CTS_HOLD_CLKS - 1) begin
                  if (strap_ok) begin
                     state_reg                <= ST_CHECK;
                     built_in_self_check_go_reg              <= 1'b1;
                     built_in_self_check_busy <= 1'b1;
                  end else begin
                     state_reg      <= ST_RUN;
                     core_reset     <= 1'b0;
                     bus_cycle_hold <= 1'b0;
                  end
               end
            end
            ST_CHECK: begin
               bus_cycle_hold <= 1'b1; // [R02]
               if (b_done) begin
                  built_in_self_check_busy <= 1'b0;
                  rseq_reg                 <= 8'd0;
                  state_reg                <= ST_RSEQ;
               end
            end
            ST_RSEQ: begin
               // Own reset sequence, no external action needed [R05]
               rseq_reg <= rseq_reg + 8'd1;
               if (rseq_reg == `CTS_RSTSEQ_CLKS - 8'd1) begin
                  core_reset     <= 1'b0;
                  bus_cycle_hold <= 1'b0;
                  state_reg      <= ST_RUN;
               end
            end
            ST_RUN: begin
               core_reset     <= 1'b0;
               bus_cycle_hold <= 1'b0;
            end
            default: begin
               state_reg <= ST_STRAP;
            end
         endcase
      end
   end

   // Test registers, reached only through the operand port [R17]
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         test_rdata   <= 32'h0000_0000;
         test_rd_done <= 1'b0;
      end else begin
         // Engine reads are internal, software sees no answer
         test_rd_done <= op_rd && !in_check;
         if (op_rd) begin
            case (op_num)
               `CTS_OPND_DATA: begin
                  test_rdata <= read_buf_reg[cur_en*32 +: 32]; // [R10] [R20]
               end
               `CTS_OPND_STATUS: begin
                  test_rdata <= status_reg;
               end
               `CTS_OPND_CONTROL: begin
                  test_rdata <= control_reg;
               end
               default: begin
                  test_rdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Data window keeps the last word written, whatever the code
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         data_win_reg <= 32'h0000_0000;
      end else if (data_wr) begin
         data_win_reg <= op_data;
      end
   end

   // Word placed at once, only when code is buffer access [R11] [R20]
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fill_buf_reg <= 128'h0;
      end else if (data_wr && cur_code == `CTS_CODE_BUF) begin
         fill_buf_reg[cur_en*32 +: 32] <= op_data; // [R08] [R10]
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         control_reg <= 32'h0000_0000;
      end else if (ctl_wr) begin
         control_reg <= op_data & `CTS_CTRL_MASK; // [R15]
      end
   end

   // A cache read overrides a status write in the same cycle
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= 32'h0000_0000;
      end else if (do_read) begin
         status_reg <= {tag_mem[new_idx],
                        valid_mem[new_set][new_en],
                        lru_mem[new_set],
                        valid_mem[new_set],
                        3'h0}; // [R14] [R19]
      end else if (stat_wr) begin
         status_reg <= op_data;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         read_buf_reg <= 128'h0;
      end else if (do_read) begin
         read_buf_reg <= data_mem[new_idx]; // [R08] [R19]
      end
   end

   // Data and tag arrays: no reset, contents only defined once written
   always @(posedge clock) begin
      if (do_write) begin
         data_mem[new_idx] <= fill_buf_reg; // [R12] [R18]
         tag_mem[new_idx]  <= status_reg[`CTS_TAG_LSB +: 21];
      end
   end

   // Valid and replacement bits per set
   genvar g;
   generate
      for (g = 0; g < `CTS_SETS; g = g + 1) begin : g_set
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               valid_mem[g] <= 4'h0;
               lru_mem[g]   <= 3'h0;
            end else if (do_flush) begin
               // Tags and data kept, no flush bus cycle [R21]
               valid_mem[g] <= 4'h0;
               lru_mem[g]   <= 3'h0;
            end else if (do_write && new_set == g) begin
               valid_mem[g][new_en] <= status_reg[`CTS_VALID_BIT]; // [R18]
               lru_mem[g]           <= lru_touch(lru_mem[g], new_en);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- tb/cts_top_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "cts_defs.vh"
module cts_top_props #(
   parameter CHECK_CLKS = `CTS_CHECK_CLKS
) (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        address_hold_input,
   input wire logic        test_wr,
   input wire logic        test_rd,
   input wire logic [2:0]  test_register_operand,
   input wire logic [31:0] test_wdata,
   input wire logic [31:0] test_rdata,
   input wire logic        test_rd_done,
   input wire logic        bus_cycle_hold,
   input wire logic        core_reset,
   input wire logic        built_in_self_check_busy,
   input wire logic [31:0] accumulator
);
   logic [31:0] busy_cnt_reg;
   logic [31:0] busy_cnt_next;
   wire         run_ok = !core_reset;
   wire         unmapped = (test_register_operand < 3'h3) ||
                           (test_register_operand > 3'h5);

   // Counts self check cycles; too long for a repetition
   always @* begin
      busy_cnt_next = built_in_self_check_busy ? busy_cnt_reg + 32'h1 : 32'h0;
   end
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt_reg <= 32'h0;
      end else begin
         busy_cnt_reg <= busy_cnt_next;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_busy_no_bus: assert property (built_in_self_check_busy |->
      bus_cycle_hold && core_reset) else $error("bus free during self check");
   a_busy_bounded: assert property (busy_cnt_reg <= CHECK_CLKS + 2)
      else $error("self check runs too long");
   a_acc_held_run: assert property (run_ok && $past(run_ok) |->
      $stable(accumulator)) else $error("result changed in normal run");
   a_seq_after_check: assert property ($fell(built_in_self_check_busy) |->
      core_reset [*8] ##1 core_reset [*7] ##1 !core_reset)
      else $error("reset sequence wrong");
   a_rd_answer: assert property (test_rd && run_ok |=> test_rd_done)
      else $error("read not answered");
   a_rd_refused: assert property (test_rd && core_reset |=> !test_rd_done)
      else $error("read answered while core held");
   a_unmapped_zero: assert property (test_rd && run_ok && unmapped |=>
      test_rdata == 32'h0) else $error("unmapped read not zero");
   a_ctrl_mask: assert property ((test_wr && !test_rd && run_ok &&
      test_register_operand == 3'h5) ##1 (test_rd && !test_wr &&
      test_register_operand == 3'h5) |=> test_rdata ==
      ($past(test_wdata, 2) & `CTS_CTRL_MASK)) else $error("control readback");
   a_status_keep: assert property ((test_wr && !test_rd && run_ok &&
      test_register_operand == 3'h4) ##1 (test_rd && !test_wr &&
      test_register_operand == 3'h4) |=> test_rdata == $past(test_wdata, 2))
      else $error("status readback");

   cover property ($fell(built_in_self_check_busy));
   cover property (test_wr && run_ok && test_register_operand == 3'h5 &&
      test_wdata[1:0] == 2'h3);
   cover property (test_rd_done && test_register_operand == 3'h3);
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int BCLK = 30000;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        hold_pin = 1'b0;
   logic        test_wr = 1'b0;
   logic        test_rd = 1'b0;
   logic [2:0]  oper = 3'h0;
   logic [31:0] wdata = 32'h0;
   wire  [31:0] rdata;
   wire         rd_done;
   wire         bus_hold;
   wire         core_reset;
   wire         busy;
   wire  [31:0] acc;
   int          num_errors = 0;
   int          n_checks = 0;
   int          n;
   logic [31:0] got;
   // Set, entry, tag of each cache row
   logic [29:0] row [0:3] = '{{7'd0, 2'd0, 21'h00001},
      {7'd127, 2'd3, 21'h1fffff}, {7'd64, 2'd1, 21'h0a5a5},
      {7'd127, 2'd2, 21'h15555}};

   always #12.5 clock = ~clock;

   cts_top #(.CHECK_CLKS(BCLK)) DUT (
      .clock(clock), .reset_n(reset_n), .address_hold_input(hold_pin),
      .test_wr(test_wr), .test_rd(test_rd), .test_register_operand(oper),
      .test_wdata(wdata), .test_rdata(rdata), .test_rd_done(rd_done),
      .bus_cycle_hold(bus_hold), .core_reset(core_reset),
      .built_in_self_check_busy(busy), .accumulator(acc));

   function automatic logic [31:0] pat(logic [6:0] s, logic [1:0] e,
                                       logic [1:0] k);
      return {1'b1, s, e, k, 20'h3c5a1};
   endfunction

   task automatic chk(input string nm, input logic [31:0] g,
                      input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic finish_test;
      if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Leaves the write strobe up so writes can run back to back
   task automatic wr(input logic [2:0] o, input logic [31:0] d);
      @(posedge clock);
      test_wr <= 1'b1;
      test_rd <= 1'b0;
      oper <= o;
      wdata <= d;
   endtask

   task automatic rd(input logic [2:0] o);
      @(posedge clock);
      test_wr <= 1'b0;
      test_rd <= 1'b1;
      oper <= o;
      @(posedge clock);
      test_rd <= 1'b0;
      #1;
      chk("rd_done", {31'h0, rd_done}, 32'h1);
      got = rdata;
   endtask

   task automatic do_reset(input int pre);
      @(posedge clock);
      reset_n <= 1'b0;
      hold_pin <= 1'b0;
      test_wr <= 1'b0;
      test_rd <= 1'b0;
      for (int i = 0; i < 15; i++) begin
         @(posedge clock);
         hold_pin <= (i >= 15 - pre);
      end
      @(posedge clock);
      reset_n <= 1'b1;
      hold_pin <= 1'b1;
      repeat (3) @(posedge clock);
      hold_pin <= 1'b0;
   endtask

   task automatic cache_wr(input logic [29:0] r);
      for (int k = 0; k < 4; k++) begin
         wr(3'h5, {28'h0, k[1:0], 2'h0});
         wr(3'h3, pat(r[29:23], r[22:21], k[1:0]));
      end
      wr(3'h4, {r[20:0], 1'b1, 10'h0});
      wr(3'h5, {21'h0, r[29:23], r[22:21], 2'h1});
   endtask

   task automatic cache_rd(input logic [6:0] s, input logic [1:0] e,
                           input logic [6:0] ps, input logic [1:0] pe,
                           input logic [20:0] t, input logic v);
      wr(3'h5, {21'h0, s, e, 2'h2});
      rd(3'h4);
      chk("status_tag", {got[31:10], 10'h0}, {t, v, 10'h0});
      chk("status_low", {29'h0, got[2:0]}, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(3'h5, {28'h0, k[1:0], 2'h0});
         rd(3'h3);
         chk("rbuf_word", got, pat(ps, pe, k[1:0]));
      end
   endtask

   initial begin
      repeat (BCLK + 20000) @(posedge clock);
      num_errors++;
      finish_test;
   end

   initial begin
      do_reset(0);
      repeat (4) @(posedge clock);
      #1;
      chk("no_check", {30'h0, busy, core_reset}, 32'h0);
      chk("acc_idle", acc, 32'h0);
      for (int i = 0; i < 4; i++) cache_wr(row[i]);
      for (int i = 0; i < 4; i++) cache_rd(row[i][29:23], row[i][22:21],
         row[i][29:23], row[i][22:21], row[i][20:0], 1'b1);
      // Data writes under a non-buffer code must not reach the fill buffer
      wr(3'h4, {21'h1abcd, 1'b1, 10'h0});
      wr(3'h5, {21'h0, 7'd9, 2'd1, 2'h1});
      wr(3'h3, 32'hdead_beef);
      wr(3'h5, {21'h0, 7'd10, 2'd2, 2'h1});
      cache_rd(7'd9, 2'd1, 7'd127, 2'd2, 21'h1abcd, 1'b1);
      cache_rd(7'd10, 2'd2, 7'd127, 2'd2, 21'h1abcd, 1'b1);
      wr(3'h5, 32'hffff_ffff);
      rd(3'h5);
      chk("ctrl_mask", got, 32'h0000_07ff);
      cache_rd(7'd64, 2'd1, 7'd64, 2'd1, 21'h0a5a5, 1'b0);
      wr(3'h4, 32'h1234_5678);
      rd(3'h4);
      chk("status_rw", got, 32'h1234_5678);
      for (int o = 0; o < 8; o++) begin
         if (o < 3 || o > 5) begin
            rd(o[2:0]);
            chk("unmapped", got, 32'h0);
         end
      end
      do_reset(6);
      for (n = 0; n < 10 && busy !== 1'b1; n++) @(posedge clock);
      #1;
      chk("check_busy", {31'h0, busy}, 32'h1);
      chk("check_hold", {31'h0, bus_hold}, 32'h1);
      @(posedge clock);
      test_rd <= 1'b1;
      oper <= 3'h4;
      @(posedge clock);
      test_rd <= 1'b0;
      #1;
      chk("refused_rd", {31'h0, rd_done}, 32'h0);
      for (n = 0; n < BCLK + 1000 && busy === 1'b1; n++) begin
         @(posedge clock);
         #1;
         if (bus_hold !== 1'b1) chk("hold_busy", {31'h0, bus_hold}, 32'h1);
      end
      chk("acc_pass", acc, 32'h0);
      chk("seq_reset", {31'h0, core_reset}, 32'h1);
      for (n = 0; n < 100 && core_reset !== 1'b0; n++) begin
         @(posedge clock);
         #1;
      end
      chk("seq_len", {31'h0, n >= 14 && n <= 17}, 32'h1);
      rd(3'h5);
      finish_test;
   end
endmodule

bind cts_top cts_top_props #(.CHECK_CLKS(CHECK_CLKS)) u_props (
   .clock(clock), .reset_n(reset_n), .address_hold_input(address_hold_input),
   .test_wr(test_wr), .test_rd(test_rd),
   .test_register_operand(test_register_operand), .test_wdata(test_wdata),
   .test_rdata(test_rdata), .test_rd_done(test_rd_done),
   .bus_cycle_hold(bus_cycle_hold), .core_reset(core_reset),
   .built_in_self_check_busy(built_in_self_check_busy),
   .accumulator(accumulator));
`default_nettype wire
